// ---- common/nv_seq_regs.svh ----
// constants for the nonvolatile erase and power sequencing command block
`ifndef NV_SEQ_REGS_SVH
`define NV_SEQ_REGS_SVH

// ***************************************
// timing
// ***************************************
`define CLK_MHZ          100
`define POR_MS           150
`define POR_CYCLES       (`POR_MS * 1000 * `CLK_MHZ)
`define NV_TICK_US       100
`define NV_TICK_CYCLES   (`NV_TICK_US * `CLK_MHZ)
`define NV_MAX_ATTEMPTS  2'h3

// ***************************************
// command bytes: value and compare mask
// ***************************************
`define CMD_LINE_RATE    8'ha0
`define MSK_LINE_RATE    8'hfc
`define CMD_TEMP_COMP    8'h24
`define MSK_TEMP_COMP    8'hfc
`define CMD_MAPPING      8'hc0
`define MSK_MAPPING      8'hf8
`define CMD_GRAY_SHADE   8'hd4
`define MSK_GRAY_SHADE   8'hfc
`define CMD_BIAS_RATIO   8'he8
`define MSK_BIAS_RATIO   8'hfc
`define CMD_BIAS_POT     8'h81
`define CMD_APC          8'h31
`define CMD_NV_POT1      8'hf4
`define CMD_NV_POT2      8'hf5
`define CMD_NV_WTIMER    8'hf6
`define CMD_NV_RTIMER    8'hf7
`define CMD_NV_MASK      8'hb9
`define CMD_NV_CTRL      8'hb8
`define CMD_DISP_ON      8'haf
`define CMD_DISP_OFF     8'hae
`define CMD_SYS_RESET    8'he2
`define MSK_EXACT        8'hff

// ***************************************
// field positions
// ***************************************
`define CTRL_EN_BIT      3
`define MAP_ROW_BIT      2
`define MAP_COL_BIT      1
`define STAT_SUCCESS_BIT 2
`define STAT_BUSY_BIT    0

// ***************************************
// nonvolatile operation codes
// ***************************************
`define NV_OP_READ       3'h1
`define NV_OP_ERASE      3'h2
`define NV_OP_PROGRAM    3'h3

// ***************************************
// reset values
// ***************************************
`define RST_LINE_RATE    2'h2
`define RST_TEMP_COMP    2'h0
`define RST_GRAY_SHADE   2'h0
`define RST_BIAS_RATIO   2'h3
`define RST_BIAS_POT     8'h00
`define RST_APC          8'h00
`define RST_NV_POT1      8'h00
`define RST_NV_POT2      8'h39
`define RST_NV_WTIMER    8'h27
`define RST_NV_RTIMER    8'h04
`define RST_NV_MASK      8'h00
`define RST_NV_CELLS     8'h00
`define RAM_AW           12

`endif

// ---- common/nv_seq_pkg.sv ----
// types shared by the command interpreter and the trim engine
package nv_seq_pkg;

   // second-byte expectation of a two-byte command
   typedef enum logic [3:0]
   {
      P_NONE     = 4'h0,
      P_NV_POT1  = 4'h1,
      P_NV_POT2  = 4'h2,
      P_WTIMER   = 4'h3,
      P_RTIMER   = 4'h4,
      P_MASK     = 4'h5,
      P_CTRL     = 4'h6,
      P_BIAS_POT = 4'h7,
      P_APC      = 4'h8
   } pend_t;

   // trim engine states
   typedef enum logic [1:0]
   {
      E_IDLE   = 2'h0,
      E_WRITE  = 2'h1,
      E_READ   = 2'h2,
      E_VERIFY = 2'h3
   } nv_state_t;

endpackage : nv_seq_pkg

// ---- design/nv_trim_engine.sv ----
// trim cell erase/program/read engine with automatic retry
`timescale 1ns/100ps
`include "nv_seq_regs.svh"

module nv_trim_engine #(
   parameter int unsigned TICK_CYCLES = `NV_TICK_CYCLES
)(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       start,
   input  wire logic [2:0] op,
   input  wire logic [7:0] mask,
   input  wire logic [7:0] wtimer,
   input  wire logic [7:0] rtimer,
   input  wire logic       hv_fault,
   output logic            busy_r,
   output logic            success_r,
   output logic [7:0]      cells_r
);

   // ***************************************
   // state
   // ***************************************
   nv_seq_pkg::nv_state_t state_r;     // engine phase
   logic [2:0]            op_r;        // latched operation
   logic [1:0]            attempt_r;   // attempts made so far
   logic [15:0]           tick_cnt_r;  // prescaler
   logic                  tick;        // one pulse per timer lsb
   logic [7:0]            phase_cnt_r; // ticks spent in phase
   logic                  phase_done;  // phase length reached
   logic                  op_ok;       // operation code is known

   assign op_ok = (op == `NV_OP_READ) || (op == `NV_OP_ERASE) || (op == `NV_OP_PROGRAM);
   assign tick  = (tick_cnt_r == 16'(TICK_CYCLES - 1));
   // a zero timer still lasts one tick
   assign phase_done = tick && (phase_cnt_r + 8'h01 >=
                       ((state_r == nv_seq_pkg::E_WRITE) ? wtimer : rtimer));

   // ***************************************
   // prescaler, runs only while busy
   // ***************************************
   always_ff @(posedge mclk)
   begin
      if (!rst_b || state_r == nv_seq_pkg::E_IDLE || tick)
         tick_cnt_r <= 16'h0000;
      else
         tick_cnt_r <= tick_cnt_r + 16'h0001;
   end

   // ***************************************
   // sequencing and retry
   // ***************************************
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         state_r     <= nv_seq_pkg::E_IDLE;
         op_r        <= 3'h0;
         attempt_r   <= 2'h0;
         phase_cnt_r <= 8'h00;
         busy_r      <= 1'b0;
         success_r   <= 1'b0;
         cells_r     <= `RST_NV_CELLS;
      end
      else
      begin
         case (state_r)
            nv_seq_pkg::E_IDLE:
            begin
               // start flags busy, clears success
               if (start && op_ok)
               begin
                  op_r        <= op;
                  attempt_r   <= 2'h0;
                  phase_cnt_r <= 8'h00;
                  busy_r      <= 1'b1;
                  success_r   <= 1'b0;
                  state_r     <= (op == `NV_OP_READ) ? nv_seq_pkg::E_READ
                                                     : nv_seq_pkg::E_WRITE;
               end
            end
            nv_seq_pkg::E_WRITE, nv_seq_pkg::E_READ:
            begin
               if (phase_done)
               begin
                  phase_cnt_r <= 8'h00;
                  state_r     <= (state_r == nv_seq_pkg::E_WRITE) ? nv_seq_pkg::E_READ
                                                                  : nv_seq_pkg::E_VERIFY;
               end
               else if (tick)
                  phase_cnt_r <= phase_cnt_r + 8'h01;
            end
            nv_seq_pkg::E_VERIFY:
            begin
               if (!hv_fault)
               begin
                  // erase clears masked cells, program sets them
                  if (op_r == `NV_OP_ERASE)
                     cells_r <= cells_r & ~mask;
                  else if (op_r == `NV_OP_PROGRAM)
                     cells_r <= cells_r | mask;
                  success_r <= 1'b1;
                  busy_r    <= 1'b0;
                  state_r   <= nv_seq_pkg::E_IDLE;
               end
               else if (attempt_r == `NV_MAX_ATTEMPTS - 2'h1)
               begin
                  // third failure aborts
                  success_r <= 1'b0;
                  busy_r    <= 1'b0;
                  state_r   <= nv_seq_pkg::E_IDLE;
               end
               else
               begin
                  // retry from the write phase, or from the read phase for a read
                  attempt_r <= attempt_r + 2'h1;
                  state_r   <= (op_r == `NV_OP_READ) ? nv_seq_pkg::E_READ
                                                     : nv_seq_pkg::E_WRITE;
               end
            end
            default:
               state_r <= nv_seq_pkg::E_IDLE;
         endcase
      end
   end

   // ***************************************
   // checks
   // ***************************************
   a_retry_abort: assert property (@(posedge mclk) disable iff (!rst_b)
      state_r == nv_seq_pkg::E_VERIFY && hv_fault && attempt_r == 2'h2
      |=> !busy_r && !success_r && state_r == nv_seq_pkg::E_IDLE)
      else $error("third failure did not abort");

   a_retry_again: assert property (@(posedge mclk) disable iff (!rst_b)
      state_r == nv_seq_pkg::E_VERIFY && hv_fault && attempt_r < 2'h2
      |=> busy_r && attempt_r == $past(attempt_r) + 2'h1)
      else $error("failure did not retry");

endmodule : nv_trim_engine

// ---- design/nv_erase_power_sequencer.sv ----
// command interpreter for trim erase, power sequencing and display on/off
`timescale 1ns/100ps
`include "nv_seq_regs.svh"

module nv_erase_power_sequencer #(
   parameter int unsigned POR_CYCLES     = `POR_CYCLES,
   parameter int unsigned NV_TICK_CYCLES = `NV_TICK_CYCLES
)(
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       cyc_valid,        // one host cycle
   input  wire logic       cd,               // 0 command, 1 data
   input  wire logic       rw,               // 0 write, 1 read
   input  wire logic [7:0] din,
   input  wire logic       hv_fault,         // trim verify failed
   output logic [7:0]      rdata_r,
   output logic            rdata_valid_r,
   output logic            por_done_r,
   output logic            display_on_r,
   output logic            sleep_r,
   output logic [1:0]      line_rate_field_r,
   output logic [1:0]      temp_comp_r,
   output logic            column_mirror_r,
   output logic            row_mirror_r,
   output logic [1:0]      gray_shade_r,
   output logic [1:0]      bias_ratio_r,
   output logic [7:0]      bias_potentiometer_value_r,
   output logic [7:0]      apc_r,
   output logic [7:0]      nv_pot1_r,
   output logic [7:0]      nv_pot2_r,
   output logic [7:0]      nv_write_timer_r,
   output logic [7:0]      nv_read_timer_r,
   output logic [7:0]      nv_bit_mask_r,
   output logic            nv_busy_flag,
   output logic            nv_success_flag,
   output logic [7:0]      nonvolatile_trim_cells
);

   // ***************************************
   // decode helpers
   // ***************************************
   // compare a byte against a command pattern
   function automatic logic match(input logic [7:0] b, input logic [7:0] v,
                                  input logic [7:0] m);
      match = ((b & m) == v);
   endfunction : match

   nv_seq_pkg::pend_t     pend_r;                 // awaited second byte
   logic [7:0]            display_ram [0:4095];   // image memory
   logic [`RAM_AW-1:0]    ram_addr_r;             // auto-increment pointer
   logic [23:0]           por_cnt_r;              // power-on delay count
   logic                  cmd_wr;                 // accepted command byte
   logic                  data_wr;                // accepted image byte
   logic                  status_rd;              // status read cycle
   logic                  data_rd;                // image read cycle
   logic                  nv_start;               // launch trim operation

   assign cmd_wr    = cyc_valid && !cd && !rw && por_done_r;
   assign data_wr   = cyc_valid &&  cd && !rw && por_done_r;
   assign status_rd = cyc_valid && !cd &&  rw;
   assign data_rd   = cyc_valid &&  cd &&  rw;
   // control byte ignored while display is on or engine busy
   assign nv_start  = cmd_wr && pend_r == nv_seq_pkg::P_CTRL && din[`CTRL_EN_BIT]
                      && !display_on_r && !nv_busy_flag;

   // ***************************************
   // power-on reset delay
   // ***************************************
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         por_cnt_r  <= 24'h000000;
         por_done_r <= 1'b0;
      end
      else if (!por_done_r)
      begin
         // commands locked out until the count expires
         if (por_cnt_r == 24'(POR_CYCLES - 1))
            por_done_r <= 1'b1;
         else
            por_cnt_r <= por_cnt_r + 24'h000001;
      end
   end

   // ***************************************
   // two-byte command tracking
   // ***************************************
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         pend_r <= nv_seq_pkg::P_NONE;
      else if (cmd_wr)
      begin
         if (pend_r != nv_seq_pkg::P_NONE)
            pend_r <= nv_seq_pkg::P_NONE;  // second byte consumed
         else if (din == `CMD_NV_POT1)
            pend_r <= nv_seq_pkg::P_NV_POT1;
         else if (din == `CMD_NV_POT2)
            pend_r <= nv_seq_pkg::P_NV_POT2;
         else if (din == `CMD_NV_WTIMER)
            pend_r <= nv_seq_pkg::P_WTIMER;
         else if (din == `CMD_NV_RTIMER)
            pend_r <= nv_seq_pkg::P_RTIMER;
         else if (din == `CMD_NV_MASK)
            pend_r <= nv_seq_pkg::P_MASK;
         else if (din == `CMD_NV_CTRL)
            pend_r <= nv_seq_pkg::P_CTRL;
         else if (din == `CMD_BIAS_POT)
            pend_r <= nv_seq_pkg::P_BIAS_POT;
         else if (din == `CMD_APC)
            pend_r <= nv_seq_pkg::P_APC;
      end
   end

   // ***************************************
   // configuration and display state
   // ***************************************
   always_ff @(posedge mclk)
   begin
      if (!rst_b || (cmd_wr && pend_r == nv_seq_pkg::P_NONE && din == `CMD_SYS_RESET))
      begin
         // hardware or software reset restores defaults
         display_on_r               <= 1'b0;
         sleep_r                    <= 1'b0;
         line_rate_field_r          <= `RST_LINE_RATE;
         temp_comp_r                <= `RST_TEMP_COMP;
         column_mirror_r            <= 1'b0;
         row_mirror_r               <= 1'b0;
         gray_shade_r               <= `RST_GRAY_SHADE;
         bias_ratio_r               <= `RST_BIAS_RATIO;
         bias_potentiometer_value_r <= `RST_BIAS_POT;
         apc_r                      <= `RST_APC;
         nv_pot1_r                  <= `RST_NV_POT1;
         nv_pot2_r                  <= `RST_NV_POT2;
         nv_write_timer_r           <= `RST_NV_WTIMER;
         nv_read_timer_r            <= `RST_NV_RTIMER;
         nv_bit_mask_r              <= `RST_NV_MASK;
      end
      else if (cmd_wr)
      begin
         case (pend_r)
            nv_seq_pkg::P_NV_POT1:  nv_pot1_r                  <= din;
            nv_seq_pkg::P_NV_POT2:  nv_pot2_r                  <= din;
            nv_seq_pkg::P_WTIMER:   nv_write_timer_r           <= din;
            nv_seq_pkg::P_RTIMER:   nv_read_timer_r            <= din;
            nv_seq_pkg::P_MASK:     nv_bit_mask_r              <= din;
            nv_seq_pkg::P_BIAS_POT: bias_potentiometer_value_r <= din;
            nv_seq_pkg::P_APC:      apc_r                      <= din;
            nv_seq_pkg::P_CTRL:     ;  // handled by the engine
            nv_seq_pkg::P_NONE:
            begin
               // single-byte commands
               if (match(din, `CMD_LINE_RATE, `MSK_LINE_RATE))
                  line_rate_field_r <= din[1:0];
               else if (match(din, `CMD_TEMP_COMP, `MSK_TEMP_COMP))
                  temp_comp_r <= din[1:0];
               else if (match(din, `CMD_MAPPING, `MSK_MAPPING))
               begin
                  row_mirror_r    <= din[`MAP_ROW_BIT];
                  column_mirror_r <= din[`MAP_COL_BIT];
               end
               else if (match(din, `CMD_GRAY_SHADE, `MSK_GRAY_SHADE))
                  gray_shade_r <= din[1:0];
               else if (match(din, `CMD_BIAS_RATIO, `MSK_BIAS_RATIO))
                  bias_ratio_r <= din[1:0];
               else if (match(din, `CMD_DISP_ON, `MSK_EXACT) && !nv_busy_flag)
               begin
                  // enable refused while engine runs
                  display_on_r <= 1'b1;
                  sleep_r      <= 1'b0;
               end
               else if (match(din, `CMD_DISP_OFF, `MSK_EXACT))
               begin
                  display_on_r <= 1'b0;
                  sleep_r      <= 1'b1;
               end
            end
            default: ;
         endcase
      end
   end

   // ***************************************
   // display memory, kept through sleep
   // ***************************************
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         ram_addr_r <= '0;
      else if (data_wr || data_rd)
         ram_addr_r <= ram_addr_r + 12'h001;
   end

   always_ff @(posedge mclk)
   begin
      // written in any display state
      if (data_wr)
         display_ram[ram_addr_r] <= din;
   end

   // ***************************************
   // read answers
   // ***************************************
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         rdata_r       <= 8'h00;
         rdata_valid_r <= 1'b0;
      end
      else
      begin
         rdata_valid_r <= status_rd || data_rd;
         if (status_rd)
         begin
            // busy in bit 0, success in bit 2
            rdata_r                    <= 8'h00;
            rdata_r[`STAT_SUCCESS_BIT] <= nv_success_flag;
            rdata_r[`STAT_BUSY_BIT]    <= nv_busy_flag;
         end
         else if (data_rd)
            rdata_r <= display_ram[ram_addr_r];
      end
   end

   // ***************************************
   // trim engine
   // ***************************************
   nv_trim_engine #(
      .TICK_CYCLES (NV_TICK_CYCLES)
   ) u_engine (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .start     (nv_start),
      .op        (din[2:0]),
      .mask      (nv_bit_mask_r),
      .wtimer    (nv_write_timer_r),
      .rtimer    (nv_read_timer_r),
      .hv_fault  (hv_fault),
      .busy_r    (nv_busy_flag),
      .success_r (nv_success_flag),
      .cells_r   (nonvolatile_trim_cells)
   );

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   a_cmd_not_ram: assert property (cmd_wr && !data_rd |=> $stable(ram_addr_r))
      else $error("command byte moved the image pointer");

   a_status_bits: assert property (status_rd |=> rdata_valid_r
      && rdata_r[`STAT_BUSY_BIT] == $past(nv_busy_flag)
      && rdata_r[`STAT_SUCCESS_BIT] == $past(nv_success_flag))
      else $error("status read wrong");

   a_erase_start: assert property (nv_start && din[2:0] == `NV_OP_ERASE
      |=> nv_busy_flag && !nv_success_flag)
      else $error("erase did not start");

   a_por_lockout: assert property (!por_done_r && cyc_valid && !cd && !rw
      && din == `CMD_DISP_ON |=> !display_on_r)
      else $error("command taken during power-on delay");

   a_sleep_ram: assert property (sleep_r && !data_wr
      |=> display_ram[$past(ram_addr_r)] == $past(display_ram[ram_addr_r]))
      else $error("image lost in sleep");

   a_image_write: assert property (data_wr && !display_on_r
      |=> display_ram[$past(ram_addr_r)] == $past(din))
      else $error("image byte not stored");

   a_nv_when_on: assert property (cmd_wr && pend_r == nv_seq_pkg::P_CTRL
      && display_on_r && !nv_busy_flag |=> !nv_busy_flag)
      else $error("trim operation started with display on");

   a_on_when_busy: assert property (nv_busy_flag && !display_on_r
      |=> !display_on_r)
      else $error("display enabled during trim operation");

endmodule : nv_erase_power_sequencer

// ---- tb/host_model.sv ----
// host controller model issuing command, data and status cycles
`timescale 1ns/100ps
module host_model (
   input  wire logic       mclk,
   input  wire logic [7:0] rdata_r,
   input  wire logic       rdata_valid_r,
   output logic            cyc_valid,
   output logic            cd,
   output logic            rw,
   output logic [7:0]      din
);
   // ***********************
   // host cycles
   // ***********************
   initial
   begin
      cyc_valid = 1'b0;
      cd = 1'b0;
      rw = 1'b0;
      din = 8'h00;
   end
   // one cycle: cd picks command or data, rw picks write or read
   task automatic xfer(input logic c, input logic r, input logic [7:0] d);
      @(posedge mclk);
      #1;
      cyc_valid = 1'b1;
      cd = c;
      rw = r;
      din = d;
      @(posedge mclk);
      #1;
      cyc_valid = 1'b0;
      din = ~d;
   endtask : xfer
   // command write, one edge left for the effect to land
   task automatic cmd(input logic [7:0] d);
      xfer(1'b0, 1'b0, d);
      @(posedge mclk);
      #1;
   endtask : cmd
   // status read, answer taken while the valid pulse stands
   task automatic rd(output logic [7:0] s, output logic v);
      xfer(1'b0, 1'b1, 8'h00);
      s = rdata_r;
      v = rdata_valid_r;
   endtask : rd
   // image read, byte taken while the valid pulse stands
   task automatic rdd(output logic [7:0] s, output logic v);
      xfer(1'b1, 1'b1, 8'h00);
      s = rdata_r;
      v = rdata_valid_r;
   endtask : rdd
endmodule : host_model

// ---- tb/tb.sv ----
// testbench for the trim erase and power sequencing command block
`timescale 1ns/100ps
module tb;
   logic       mclk = 1'b0;
   logic       rst_b, hv_fault, cyc_valid, cd, rw, rdata_valid_r, por_done_r;
   logic       display_on_r, sleep_r, cm, rm, busy, succ;
   logic [7:0] din, rdata_r, pot2, wt, rt, bpot, mask, s, apc, pot1, cells;
   logic [1:0] lr, tc, gs, br;
   logic       v;
   int         fails = 0, samples_checked = 0, cycles = 0, np, nf;
   always #5 mclk = ~mclk;
   host_model host_u (.mclk(mclk), .rdata_r(rdata_r), .rdata_valid_r(rdata_valid_r),
      .cyc_valid(cyc_valid), .cd(cd), .rw(rw), .din(din));
   nv_erase_power_sequencer #(.POR_CYCLES(20), .NV_TICK_CYCLES(4)) dut_u (
      .mclk(mclk), .rst_b(rst_b), .cyc_valid(cyc_valid), .cd(cd), .rw(rw), .din(din),
      .hv_fault(hv_fault), .rdata_r(rdata_r), .rdata_valid_r(rdata_valid_r),
      .por_done_r(por_done_r), .display_on_r(display_on_r), .sleep_r(sleep_r),
      .line_rate_field_r(lr), .temp_comp_r(tc), .column_mirror_r(cm), .row_mirror_r(rm),
      .gray_shade_r(gs), .bias_ratio_r(br), .bias_potentiometer_value_r(bpot), .apc_r(apc),
      .nv_pot1_r(pot1), .nv_pot2_r(pot2), .nv_write_timer_r(wt), .nv_read_timer_r(rt),
      .nv_bit_mask_r(mask), .nv_busy_flag(busy), .nv_success_flag(succ),
      .nonvolatile_trim_cells(cells));
   // ***********************
   // checking and closing
   // ***********************
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // hang guard
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         report_and_stop();
      end
   end
   // start a trim operation, check busy, poll status with a bounded loop
   task automatic nv_op(input logic [7:0] code, input logic eb, output int n);
      n = 0;
      host_u.cmd(8'hb8);
      host_u.cmd(code);
      chk("busy after start", {7'h0, eb}, {7'h0, busy});
      host_u.rd(s, v);
      while (s[0] !== 1'b0 && n < 500)
      begin
         host_u.rd(s, v);
         n++;
      end
   endtask : nv_op
   // ***********************
   // main sequence
   // ***********************
   initial
   begin
      rst_b = 1'b0;
      hv_fault = 1'b0;
      repeat (3) @(posedge mclk);
      #1 rst_b = 1'b1;
      chk("line rate rst", 8'h02, {6'h0, lr});
      chk("bias ratio rst", 8'h03, {6'h0, br});
      chk("pot2 rst", 8'h39, pot2);
      chk("wtimer rst", 8'h27, wt);
      chk("rtimer rst", 8'h04, rt);
      chk("cells rst", 8'h00, cells);
      host_u.cmd(8'ha3);
      chk("write in por delay", 8'h02, {6'h0, lr});
      host_u.rd(s, v);
      chk("status valid", 8'h01, {7'h0, v});
      chk("status in por", 8'h00, s);
      repeat (30) @(posedge mclk);
      #1 chk("por done", 8'h01, {7'h0, por_done_r});
      host_u.cmd(8'ha3);
      chk("line rate top", 8'h03, {6'h0, lr});
      host_u.cmd(8'hf4);
      host_u.cmd(8'h00);
      host_u.cmd(8'hf5);
      host_u.cmd(8'h39);
      host_u.cmd(8'hf6);
      host_u.cmd(8'h02);
      host_u.cmd(8'hf7);
      host_u.cmd(8'h01);
      chk("pot1", 8'h00, pot1);
      chk("pot2", 8'h39, pot2);
      chk("timers", 8'h21, {wt[3:0], rt[3:0]});
      host_u.cmd(8'hb9);
      host_u.cmd(8'h3f);
      chk("mask", 8'h3f, mask);
      nv_op(8'h0a, 1'b1, np);
      chk("erase pass status", 8'h04, s);
      chk("success flag", 8'h01, {7'h0, succ});
      nv_op(8'h0b, 1'b1, nf);
      chk("program cells", 8'h3f, cells);
      nv_op(8'h09, 1'b1, nf);
      chk("read op status", 8'h04, s);
      chk("read keeps cells", 8'h3f, cells);
      hv_fault = 1'b1;
      nv_op(8'h0a, 1'b1, nf);
      hv_fault = 1'b0;
      chk("erase fail status", 8'h00, s);
      chk("abort keeps cells", 8'h3f, cells);
      chk("retries longer", 8'h01, {7'h0, nf > 2 * np});
      nv_op(8'h0a, 1'b1, np);
      chk("erase clears cells", 8'h00, cells);
      nv_op(8'h0d, 1'b0, np);
      chk("bad op ignored", 8'h04, s);
      host_u.cmd(8'h31);
      host_u.cmd(8'h5c);
      chk("apc", 8'h5c, apc);
      host_u.cmd(8'h25);
      host_u.cmd(8'hc6);
      chk("temp comp", 8'h01, {6'h0, tc});
      chk("mirrors", 8'h03, {6'h0, rm, cm});
      host_u.cmd(8'hd5);
      chk("gray shade", 8'h01, {6'h0, gs});
      host_u.cmd(8'hea);
      host_u.cmd(8'h81);
      host_u.xfer(1'b1, 1'b0, 8'haf);
      host_u.cmd(8'h5a);
      chk("bias ratio", 8'h02, {6'h0, br});
      chk("bias pot", 8'h5a, bpot);
      chk("data not command", 8'h00, {7'h0, display_on_r});
      host_u.cmd(8'haf);
      chk("display on", 8'h01, {7'h0, display_on_r});
      nv_op(8'h0a, 1'b0, np);
      chk("op while on", 8'h04, s);
      host_u.cmd(8'hae);
      chk("sleep", 8'h02, {6'h0, sleep_r, display_on_r});
      host_u.xfer(1'b1, 1'b0, 8'h11);
      host_u.xfer(1'b1, 1'b0, 8'h22);
      chk("sleep kept", 8'h02, {6'h0, sleep_r, display_on_r});
      host_u.cmd(8'haf);
      chk("resume", 8'h01, {6'h0, sleep_r, display_on_r});
      host_u.cmd(8'he2);
      chk("sw reset line rate", 8'h02, {6'h0, lr});
      chk("sw reset bias", 8'h03, {6'h0, br});
      chk("sw reset pot", 8'h00, bpot);
      chk("sw reset display", 8'h00, {6'h0, sleep_r, display_on_r});
      chk("sw reset apc", 8'h00, apc);
      // second hardware reset: delay restarts, image memory kept
      rst_b = 1'b0;
      repeat (3) @(posedge mclk);
      #1 rst_b = 1'b1;
      chk("por restart", 8'h00, {7'h0, por_done_r});
      host_u.cmd(8'haf);
      chk("enable in por delay", 8'h00, {7'h0, display_on_r});
      host_u.rdd(s, v);
      chk("ram 0", 8'haf, s);
      host_u.rdd(s, v);
      chk("ram 1", 8'h11, s);
      host_u.rdd(s, v);
      chk("ram 2", 8'h22, s);
      chk("ram read valid", 8'h01, {7'h0, v});
      report_and_stop();
   end
endmodule : tb
